// [fbs_pkg.sv]
// Notes on behaviour
// - bypass, sample/preload and external test instructions are supported.
// - with the scan option on, three pins are test inputs, one is test output.
// - no test reset pin; only the mode-select line or the option strap resets the controller.
// - sixteen-state controller, instruction register with decodes, selectable data registers.
// - each I/O block has three boundary cells: input, output, then enable.
// - pins that are not full I/O blocks get fewer cells, except the output-only mode pin, which gets three.
// - both input-only mode pins get an input cell; output-only mode pin gets three.
// - program-request, configuration clock and done pins have no boundary cells.
// - capture-data under external test samples every input, output and enable cell.
// - boundary bit 0 captures test-output enable, bit 1 captures test-output value.
// - the last boundary bit is an update cell driving an internal net.
// - bypass is one flip-flop between test data in and test data out.
// - two user selects decode user instructions; selected user scan data goes out.
// - a data-register clock goes to fabric for user test registers.
// - idle output is the NAND of test clock and run-test/idle.
// - instructions exist to load configuration and to read it back.

package fbs_pkg;

	localparam int IR_W = 3;
	typedef logic [IR_W-1:0] fbs_instr_t;

	localparam fbs_instr_t INSTR_EXTEST    = 3'h0;
	localparam fbs_instr_t INSTR_SAMPLE    = 3'h1;
	localparam fbs_instr_t INSTR_USER_A    = 3'h2;
	localparam fbs_instr_t INSTR_USER_B    = 3'h3;
	localparam fbs_instr_t INSTR_READBACK  = 3'h4;
	localparam fbs_instr_t INSTR_CONFIGURE = 3'h5;
	localparam fbs_instr_t INSTR_BYPASS    = 3'h7;

	// value loaded into the instruction shifter on capture-ir
	localparam fbs_instr_t IR_CAPTURE_VAL = 3'h1;
	localparam fbs_instr_t IR_RESET_VAL   = INSTR_BYPASS;
	localparam logic       BYPASS_CAPTURE = 1'h0;

	// reset value of the {tdi, tms, tck} synchroniser; tms idles high
	localparam logic [2:0] PIN_SYNC_RST = 3'h2;
	localparam int         PIN_TCK      = 0;
	localparam int         PIN_TMS      = 1;
	localparam int         PIN_TDI      = 2;

	// boundary register layout, bit 0 sits next to test data out
	localparam int POS_TDO_T     = 0;
	localparam int POS_TDO_O     = 1;
	localparam int POS_IOB_BASE  = 2;
	localparam int CELLS_PER_IOB = 3;
	localparam int CELL_IN       = 0;
	localparam int CELL_OUT      = 1;
	localparam int CELL_TRI      = 2;
	localparam int MODE_CELLS    = 5;
	localparam int UPD_CELLS     = 1;

	function automatic int fbs_bsr_len(input int n_iob);
		return POS_IOB_BASE + CELLS_PER_IOB * n_iob + MODE_CELLS + UPD_CELLS;
	endfunction : fbs_bsr_len

	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
		ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
		ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} fbs_tap_state_t;

endpackage : fbs_pkg

// [fbs_bsr.sv]
`timescale 1ns/100ps
`default_nettype none

module fbs_bsr #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// controls, one-cycle pulses on test clock rise
	input  wire logic             capture_en,
	input  wire logic             shift_en,
	input  wire logic             update_en,
	// data
	input  wire logic             scan_in,
	input  wire logic [WIDTH-1:0] capture_vec,
	output logic                  scan_out,
	output logic      [WIDTH-1:0] update_q
);

	logic [WIDTH-1:0] shift_q;

	// refused at elaboration: the shift below needs two bits at least
	if (WIDTH < 2) begin : g_bad_width
		$error("fbs_bsr width too small");
	end

	// shifts toward bit 0; update stage holds pins steady while shifting
	always_ff @(posedge clk) begin
		if (reset) begin
			shift_q  <= '0;
			update_q <= '0;
		end else begin
			if (capture_en) shift_q <= capture_vec;
			else if (shift_en) shift_q <= {scan_in, shift_q[WIDTH-1:1]};
			if (update_en) update_q <= shift_q;
		end
	end

	assign scan_out = shift_q[0];

endmodule : fbs_bsr

`default_nettype wire

// [fbs_tap.sv]
`timescale 1ns/100ps
`default_nettype none

module fbs_tap
	import fbs_pkg::*;
#(
	parameter int N_IOB = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// option strap from configuration logic
	input  wire logic             scan_option_en,
	// test pins
	input  wire logic             tck_pin,
	input  wire logic             tms_pin,
	input  wire logic             tdi_pin,
	output logic                  tdo_pin_out,
	output logic                  tdo_pin_oe,
	// user function of the test output pin when the option is off
	input  wire logic             user_tdo_out,
	input  wire logic             user_tdo_oe,
	// i/o blocks
	input  wire logic [N_IOB-1:0] iob_pad_in,
	input  wire logic [N_IOB-1:0] iob_core_out,
	input  wire logic [N_IOB-1:0] iob_core_oe,
	output logic      [N_IOB-1:0] iob_pad_out,
	output logic      [N_IOB-1:0] iob_pad_oe,
	output logic      [N_IOB-1:0] iob_core_in,
	// mode pins
	input  wire logic             mode_select_in_low,
	input  wire logic             mode_select_in_high,
	input  wire logic             mode_select_out_mid_core,
	input  wire logic             mode_select_out_mid_core_oe,
	output logic                  mode_select_out_mid,
	output logic                  mode_select_out_mid_oe,
	output logic                  mode_select_in_low_core,
	output logic                  mode_select_in_high_core,
	// fabric user scan
	input  wire logic             user_scan_out_a,
	input  wire logic             user_scan_out_b,
	output logic                  user_instr_select_a,
	output logic                  user_instr_select_b,
	output logic                  user_data_reg_clock,
	output logic                  user_idle_strobe,
	output logic                  user_scan_tdi,
	output logic                  internal_update_cell,
	// configuration path
	input  wire logic             config_dout,
	input  wire logic             readback_data,
	output logic                  config_scan_data,
	output logic                  config_scan_strobe,
	output logic                  readback_shift
);

	import fbs_pkg::*;

	localparam int BSR_W   = fbs_bsr_len(N_IOB);
	localparam int POS_M0  = POS_IOB_BASE + CELLS_PER_IOB * N_IOB;
	localparam int POS_M2  = POS_M0 + 1;
	localparam int POS_M1  = POS_M0 + 2;
	localparam int POS_UPD = BSR_W - 1;

	if (N_IOB < 1) begin : g_bad_n_iob
		$error("fbs_tap needs at least one i/o block");
	end

	function automatic fbs_tap_state_t fbs_tap_next(input fbs_tap_state_t s, input logic tms);
		fbs_tap_state_t n;
		n = s;
		case (s)
			ST_TLR:      n = tms ? ST_TLR : ST_RTI;
			ST_RTI:      n = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR:   n = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR:   n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: n = tms ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: n = tms ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR:   n = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR:   n = tms ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR:   n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: n = tms ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: n = tms ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR:   n = tms ? ST_SEL_DR : ST_RTI;
			default:     n = ST_TLR;
		endcase
		return n;
	endfunction : fbs_tap_next

	////////////////////////////////////////////////////////////////////////////

	// synchronisers; only the second stage is read
	logic [2:0]       pin_meta_q;
	logic [2:0]       pin_q;
	logic             tck_prev_q;
	logic [N_IOB-1:0] iob_meta_q;
	logic [N_IOB-1:0] iob_in_q;
	logic [1:0]       mode_meta_q;
	logic [1:0]       mode_in_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_meta_q  <= PIN_SYNC_RST;
			pin_q       <= PIN_SYNC_RST;
			tck_prev_q  <= 1'b0;
			iob_meta_q  <= '0;
			iob_in_q    <= '0;
			mode_meta_q <= '0;
			mode_in_q   <= '0;
		end else begin
			pin_meta_q  <= {tdi_pin, tms_pin, tck_pin};
			pin_q       <= pin_meta_q;
			tck_prev_q  <= pin_q[PIN_TCK];
			iob_meta_q  <= iob_pad_in;
			iob_in_q    <= iob_meta_q;
			mode_meta_q <= {mode_select_in_high, mode_select_in_low};
			mode_in_q   <= mode_meta_q;
		end
	end

	wire tck_s    = pin_q[PIN_TCK];
	wire tms_s    = pin_q[PIN_TMS];
	wire tdi_s    = pin_q[PIN_TDI];
	// test clock must stay well below clk/4 for edges to be seen
	wire tck_rise = tck_s & ~tck_prev_q;
	wire tck_fall = ~tck_s & tck_prev_q;

	////////////////////////////////////////////////////////////////////////////

	fbs_tap_state_t state_q;
	fbs_tap_state_t state_d;

	// no test reset pin: only tms high or the option strap returns to reset
	assign state_d = !scan_option_en ? ST_TLR :
	                 tck_rise ? fbs_tap_next(state_q, tms_s) : state_q;

	always_ff @(posedge clk) begin
		if (reset) state_q <= ST_TLR;
		else state_q <= state_d;
	end

	wire in_tlr      = state_q == ST_TLR;
	wire in_shift_ir = state_q == ST_SHIFT_IR;
	wire in_shift_dr = state_q == ST_SHIFT_DR;
	wire in_cap_dr   = state_q == ST_CAP_DR;
	wire dr_capture  = tck_rise & in_cap_dr;
	wire dr_shift    = tck_rise & in_shift_dr;
	wire dr_update   = tck_rise & (state_q == ST_UPD_DR);

	////////////////////////////////////////////////////////////////////////////

	fbs_instr_t ir_shift_q;
	fbs_instr_t ir_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			ir_shift_q <= IR_CAPTURE_VAL;
			ir_q       <= IR_RESET_VAL;
		end else if (in_tlr) begin
			ir_q <= IR_RESET_VAL;
		end else if (tck_rise) begin
			if (state_q == ST_CAP_IR) ir_shift_q <= IR_CAPTURE_VAL;
			else if (in_shift_ir) ir_shift_q <= {tdi_s, ir_shift_q[IR_W-1:1]};
			else if (state_q == ST_UPD_IR) ir_q <= ir_shift_q;
		end
	end

	// instruction decodes
	wire is_extest    = ir_q == INSTR_EXTEST;
	wire is_sample    = ir_q == INSTR_SAMPLE;
	wire is_user_a    = ir_q == INSTR_USER_A;
	wire is_user_b    = ir_q == INSTR_USER_B;
	wire is_readback  = ir_q == INSTR_READBACK;
	wire is_configure = ir_q == INSTR_CONFIGURE;
	wire bsr_sel      = is_extest | is_sample;
	wire user_sel     = is_user_a | is_user_b;

	////////////////////////////////////////////////////////////////////////////

	// bypass: captures zero, one stage of retiming between tdi and tdo
	logic bypass_q;

	always_ff @(posedge clk) begin
		if (reset) bypass_q <= BYPASS_CAPTURE;
		else if (dr_capture) bypass_q <= BYPASS_CAPTURE;
		else if (dr_shift) bypass_q <= tdi_s;
	end

	////////////////////////////////////////////////////////////////////////////

	// boundary register; program, config clock and done pins have no cells
	logic [BSR_W-1:0] cap_vec;
	logic [BSR_W-1:0] upd_vec;
	logic             bsr_so;
	logic             tdo_out_q;
	logic             tdo_oe_q;

	always_comb begin
		cap_vec                        = '0;
		cap_vec[POS_TDO_T]             = tdo_oe_q;
		cap_vec[POS_TDO_O]             = tdo_out_q;
		for (int k = 0; k < N_IOB; k++) begin
			cap_vec[POS_IOB_BASE + CELLS_PER_IOB * k + CELL_IN]  = iob_in_q[k];
			cap_vec[POS_IOB_BASE + CELLS_PER_IOB * k + CELL_OUT] = iob_pad_out[k];
			cap_vec[POS_IOB_BASE + CELLS_PER_IOB * k + CELL_TRI] = iob_pad_oe[k];
		end
		cap_vec[POS_M0]                = mode_in_q[0];
		cap_vec[POS_M2]                = mode_in_q[1];
		cap_vec[POS_M1 + CELL_IN]      = mode_select_out_mid;
		cap_vec[POS_M1 + CELL_OUT]     = mode_select_out_mid;
		cap_vec[POS_M1 + CELL_TRI]     = mode_select_out_mid_oe;
		cap_vec[POS_UPD]               = internal_update_cell;
	end

	fbs_bsr #(
		.WIDTH(BSR_W)
	) u_bsr (
		.clk        (clk),
		.reset      (reset),
		.capture_en (dr_capture & bsr_sel),
		.shift_en   (dr_shift & bsr_sel),
		.update_en  (dr_update & bsr_sel),
		.scan_in    (tdi_s),
		.capture_vec(cap_vec),
		.scan_out   (bsr_so),
		.update_q   (upd_vec)
	);

	////////////////////////////////////////////////////////////////////////////

	// pin drive: update cells under external test, pins released while configuring
	logic [N_IOB-1:0] iob_out_d;
	logic [N_IOB-1:0] iob_oe_d;

	always_comb begin
		for (int k = 0; k < N_IOB; k++) begin
			iob_out_d[k] = is_extest ? upd_vec[POS_IOB_BASE + CELLS_PER_IOB * k + CELL_OUT]
			                         : iob_core_out[k];
			iob_oe_d[k]  = is_configure ? 1'b0 :
			               is_extest ? upd_vec[POS_IOB_BASE + CELLS_PER_IOB * k + CELL_TRI]
			                         : iob_core_oe[k];
		end
	end

	wire m1_out_d = is_extest ? upd_vec[POS_M1 + CELL_OUT] : mode_select_out_mid_core;
	wire m1_oe_d  = is_configure ? 1'b0 :
	                is_extest ? upd_vec[POS_M1 + CELL_TRI] : mode_select_out_mid_core_oe;

	always_ff @(posedge clk) begin
		if (reset) begin
			iob_pad_out              <= '0;
			iob_pad_oe               <= '0;
			iob_core_in              <= '0;
			mode_select_out_mid      <= 1'b0;
			mode_select_out_mid_oe   <= 1'b0;
			mode_select_in_low_core  <= 1'b0;
			mode_select_in_high_core <= 1'b0;
			internal_update_cell     <= 1'b0;
		end else begin
			iob_pad_out              <= iob_out_d;
			iob_pad_oe               <= iob_oe_d;
			iob_core_in              <= iob_in_q;
			mode_select_out_mid      <= m1_out_d;
			mode_select_out_mid_oe   <= m1_oe_d;
			mode_select_in_low_core  <= mode_in_q[0];
			mode_select_in_high_core <= mode_in_q[1];
			internal_update_cell     <= upd_vec[POS_UPD];
		end
	end

	////////////////////////////////////////////////////////////////////////////

	// test data out source
	wire dr_tdo = bsr_sel      ? bsr_so :
	              is_user_a    ? user_scan_out_a :
	              is_user_b    ? user_scan_out_b :
	              is_readback  ? readback_data :
	              is_configure ? config_dout :
	              bypass_q;
	wire shift_bit = in_shift_ir ? ir_shift_q[0] : dr_tdo;

	// oe lags state by half a test clock so the far end never sees a glitch
	always_ff @(posedge clk) begin
		if (reset) begin
			tdo_out_q <= 1'b0;
			tdo_oe_q  <= 1'b0;
		end else if (!scan_option_en) begin
			tdo_out_q <= user_tdo_out;
			tdo_oe_q  <= user_tdo_oe;
		end else if (in_tlr) begin
			// user drive must not linger once the option is switched on
			tdo_oe_q  <= 1'b0;
		end else if (tck_fall) begin
			tdo_out_q <= shift_bit;
			tdo_oe_q  <= in_shift_ir | in_shift_dr;
		end
	end

	assign tdo_pin_out = tdo_out_q;
	assign tdo_pin_oe  = tdo_oe_q;

	////////////////////////////////////////////////////////////////////////////

	// fabric and configuration side strobes
	always_ff @(posedge clk) begin
		if (reset) begin
			user_instr_select_a <= 1'b0;
			user_instr_select_b <= 1'b0;
			user_data_reg_clock <= 1'b1;
			user_idle_strobe    <= 1'b1;
			user_scan_tdi       <= 1'b0;
			config_scan_data    <= 1'b0;
			config_scan_strobe  <= 1'b0;
			readback_shift      <= 1'b0;
		end else begin
			user_instr_select_a <= is_user_a;
			user_instr_select_b <= is_user_b;
			user_data_reg_clock <= (user_sel & (in_cap_dr | in_shift_dr)) ? tck_s : 1'b1;
			user_idle_strobe    <= ~(tck_s & (state_q == ST_RTI));
			user_scan_tdi       <= tdi_s;
			config_scan_data    <= tdi_s;
			config_scan_strobe  <= dr_shift & is_configure;
			readback_shift      <= dr_shift & is_readback;
		end
	end

endmodule : fbs_tap

`default_nettype wire

// [fbs_tap_chk.sv]
`timescale 1ns/100ps
`default_nettype none

module fbs_tap_chk #(
	parameter int N_IOB = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// test pins
	input wire logic scan_option_en,
	input wire logic tck_pin,
	input wire logic tdi_pin,
	input wire logic tdo_pin_out,
	input wire logic tdo_pin_oe,
	// fabric side
	input wire logic user_instr_select_a,
	input wire logic user_instr_select_b,
	input wire logic user_data_reg_clock,
	input wire logic user_idle_strobe,
	input wire logic user_scan_tdi,
	input wire logic config_scan_data,
	input wire logic config_scan_strobe,
	input wire logic readback_shift
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////////
	// pin sequences take five samples to cover the two sync stages, edge detect and output register; the others take four
	sequence s_tck_low;
		!tck_pin [*5];
	endsequence
	sequence s_tdi_still;
		$stable(tdi_pin) [*5];
	endsequence
	sequence s_no_user;
		(!user_instr_select_a && !user_instr_select_b) [*4];
	endsequence
	sequence s_opt_off;
		!scan_option_en [*4];
	endsequence

	////////////////////////////////////////////////////////////////////////////
	AST_RESET_VALS: assert property (disable iff (1'b0)
		reset |=> !tdo_pin_oe && user_idle_strobe && user_data_reg_clock)
		else $error("outputs not at reset values");
	AST_IDLE_HIGH: assert property (s_tck_low |-> user_idle_strobe)
		else $error("idle strobe low with test clock low");
	AST_DRCK_IDLE: assert property (s_no_user |-> user_data_reg_clock)
		else $error("data register clock moved without user instruction");
	AST_OPT_OFF: assert property (s_opt_off |-> !user_instr_select_a
		&& !user_instr_select_b && !config_scan_strobe && !readback_shift)
		else $error("test logic active with scan option off");
	AST_SEL_EXCL: assert property (!(user_instr_select_a && user_instr_select_b))
		else $error("both user selects high");
	AST_CFG_PULSE: assert property (config_scan_strobe |=> !config_scan_strobe [*8])
		else $error("configure strobe longer than one pulse per clock rise");
	AST_RB_PULSE: assert property (readback_shift |=> !readback_shift [*8])
		else $error("readback shift longer than one pulse per clock rise");
	AST_STB_EXCL: assert property (!(config_scan_strobe && readback_shift))
		else $error("configure and readback strobes together");
	AST_SYNC_TDI: assert property (s_tdi_still |->
		config_scan_data == tdi_pin && user_scan_tdi == tdi_pin)
		else $error("synchronised test data in differs from pin");
	AST_TDO_FALL: assert property (scan_option_en && $past(scan_option_en)
		&& ($changed(tdo_pin_oe) || $changed(tdo_pin_out)) |-> !tck_pin)
		else $error("test data out changed while test clock high");
endmodule : fbs_tap_chk

`default_nettype wire

// [fbs_tester.sv]
`timescale 1ns/100ps
`default_nettype none

module fbs_tester (
	// clock
	input wire logic clk,
	// test pins
	output logic     tck,
	output logic     tms,
	output logic     tdi,
	input wire logic tdo
);
	// clock parks low between frames; mode-select idles high
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// one 160 ns test clock period; tdo read just before the rise
	task automatic tick(input logic m, input logic d, output logic q);
		@(posedge clk);
		tms <= m;
		tdi <= d;
		repeat (15) @(posedge clk);
		q = tdo;
		tck <= 1'b1;
		repeat (16) @(posedge clk);
		tck <= 1'b0;
	endtask : tick

	// no reset pin exists, so five high mode-select rises are the tester's only way back
	task automatic reset_tap;
		logic b;
		repeat (5) tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
	endtask : reset_tap

	task automatic load_ir(input logic [2:0] v, output logic [2:0] cap);
		logic b;
		tick(1'b1, 1'b0, b);
		tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
		tick(1'b0, 1'b0, b);
		for (int i = 0; i < 3; i++) begin
			tick(i == 2, v[i], b);
			cap[i] = b;
		end
		tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
	endtask : load_ir

	task automatic scan_dr(input int n, input logic [15:0] din, output logic [15:0] dout);
		logic b;
		dout = '0;
		tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
		tick(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], b);
			dout[i] = b;
		end
		tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
	endtask : scan_dr
endmodule : fbs_tester

`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none

module tb;
	import fbs_pkg::*;
	localparam int NI = 2;
	localparam logic [13:0] U = 14'h3A5A;

	logic clk = 1'b0;
	logic reset = 1'b1;
	logic opt_en = 1'b1;
	logic utdo = 1'b0;
	logic utdo_oe = 1'b0;
	logic [NI-1:0] pin = 2'h2, cout = 2'h1, coe = 2'h3, pout, poe;
	logic m_lo = 1'b1, m_hi = 1'b0, m_mid = 1'b1, m_mid_oe = 1'b1;
	logic usa = 1'b0, usb = 1'b0, cdout = 1'b0, rbd = 1'b0;
	logic tck, tms, tdi, tdo_out, tdo_oe, tdo_w, mid, mid_oe, sel_a, sel_b;
	logic drck, idle, utdi, upd, cdat, cstb, rbs, b;
	logic [NI-1:0] cin;
	logic mlc, mhc;
	logic [15:0] q;
	logic [2:0] ir_q;
	int miscompares = 0;
	int tests_run = 0;
	int cstb_n = 0, rbs_n = 0, idle_n = 0, drck_n = 0;

	always #2.5 clk = ~clk;
	// pull-up on the test output wire
	assign tdo_w = tdo_oe ? tdo_out : 1'b1;
	always @(posedge clk) begin
		cstb_n += cstb;
		rbs_n += rbs;
		idle_n += !idle;
		drck_n += !drck;
	end

	fbs_tap #(.N_IOB(NI)) dut (.clk(clk), .reset(reset), .scan_option_en(opt_en),
		.tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi), .tdo_pin_out(tdo_out),
		.tdo_pin_oe(tdo_oe), .user_tdo_out(utdo), .user_tdo_oe(utdo_oe),
		.iob_pad_in(pin), .iob_core_out(cout), .iob_core_oe(coe), .iob_pad_out(pout),
		.iob_pad_oe(poe), .iob_core_in(cin), .mode_select_in_low(m_lo),
		.mode_select_in_high(m_hi), .mode_select_out_mid_core(m_mid),
		.mode_select_out_mid_core_oe(m_mid_oe), .mode_select_out_mid(mid),
		.mode_select_out_mid_oe(mid_oe), .mode_select_in_low_core(mlc),
		.mode_select_in_high_core(mhc), .user_scan_out_a(usa), .user_scan_out_b(usb),
		.user_instr_select_a(sel_a), .user_instr_select_b(sel_b),
		.user_data_reg_clock(drck), .user_idle_strobe(idle), .user_scan_tdi(utdi),
		.internal_update_cell(upd), .config_dout(cdout), .readback_data(rbd),
		.config_scan_data(cdat), .config_scan_strobe(cstb), .readback_shift(rbs));

	fbs_tester u_tst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_cnt(input int got, input int exp);
		chk(got[15:0], exp[15:0]);
	endtask : chk_cnt

	task automatic tally_and_finish;
		$display("compares %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////
	task automatic t_ir_idle;
		u_tst.reset_tap();
		u_tst.load_ir(INSTR_BYPASS, ir_q);
		chk({13'h0, ir_q}, {13'h0, IR_CAPTURE_VAL});
		chk({13'h0, sel_a, sel_b, tdo_oe}, 16'h0);
		// let the last high phase drain out of the idle strobe before counting
		repeat (8) @(posedge clk);
		idle_n = 0;
		u_tst.tick(1'b0, 1'b0, b);
		repeat (8) @(posedge clk);
		chk_cnt(idle_n, 16);
	endtask : t_ir_idle

	// reserved code 3'h6 must behave as bypass
	task automatic t_bypass;
		logic [2:0] ins [2] = '{INSTR_BYPASS, 3'h6};
		foreach (ins[i]) begin
			u_tst.load_ir(ins[i], ir_q);
			u_tst.scan_dr(16, 16'hA5C3, q);
			chk(q, {15'h25C3, BYPASS_CAPTURE});
		end
	endtask : t_bypass

	task automatic t_user;
		usa <= 1'b1;
		u_tst.load_ir(INSTR_USER_A, ir_q);
		chk({14'h0, sel_a, sel_b}, 16'h2);
		drck_n = 0;
		u_tst.scan_dr(8, 16'h0, q);
		chk(q, 16'h00FF);
		chk_cnt(drck_n > 0, 1);
		u_tst.load_ir(INSTR_USER_B, ir_q);
		chk({14'h0, sel_a, sel_b}, 16'h1);
		u_tst.scan_dr(8, 16'hFFFF, q);
		chk(q, 16'h0000);
	endtask : t_user

	// sample then preload, drive the pads from the preloaded cells, capture under extest
	task automatic t_sample_extest;
		u_tst.load_ir(INSTR_SAMPLE, ir_q);
		u_tst.scan_dr(16, {U, 2'b10}, q);
		chk(q & 16'hDFFD, {2'b10, 1'b0, m_mid_oe, m_mid, m_mid, m_hi, m_lo, coe[1],
			cout[1], pin[1], coe[0], cout[0], pin[0], 2'b00});
		chk({12'h0, cin, mlc, mhc}, {12'h0, pin, m_lo, m_hi});
		chk({15'h0, upd}, {15'h0, U[13]});
		u_tst.load_ir(INSTR_EXTEST, ir_q);
		repeat (8) @(posedge clk);
		chk({9'h0, pout, poe, mid, mid_oe, upd},
			{9'h0, U[6], U[3], U[7], U[4], U[11], U[12], U[13]});
		u_tst.scan_dr(14, 16'h0, q);
		chk(q & 16'hFFFD, {2'b00, U[13], U[12], U[11], U[11], m_hi, m_lo, U[7],
			U[6], pin[1], U[4], U[3], pin[0], 2'b00});
		chk({12'h0, pout, poe}, 16'h0);
		u_tst.reset_tap();
		repeat (8) @(posedge clk);
		chk({12'h0, pout, poe}, {12'h0, cout, coe});
	endtask : t_sample_extest

	task automatic t_cfg_rb;
		cdout <= 1'b1;
		u_tst.load_ir(INSTR_CONFIGURE, ir_q);
		chk({14'h0, poe}, 16'h0);
		cstb_n = 0;
		u_tst.scan_dr(4, 16'h5, q);
		chk(q, 16'h000F);
		chk_cnt(cstb_n, 4);
		u_tst.load_ir(INSTR_READBACK, ir_q);
		rbs_n = 0;
		u_tst.scan_dr(4, 16'hA, q);
		chk(q, 16'h0000);
		chk_cnt(rbs_n, 4);
	endtask : t_cfg_rb

	task automatic t_opt_off;
		opt_en <= 1'b0;
		utdo <= 1'b1;
		utdo_oe <= 1'b1;
		repeat (8) @(posedge clk);
		chk({14'h0, tdo_oe, tdo_out}, 16'h3);
		u_tst.load_ir(INSTR_USER_A, ir_q);
		chk({14'h0, sel_a, sel_b}, 16'h0);
		opt_en <= 1'b1;
		utdo_oe <= 1'b0;
		repeat (8) @(posedge clk);
		chk({15'h0, tdo_oe}, 16'h0);
		u_tst.reset_tap();
	endtask : t_opt_off

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		t_ir_idle();
		t_bypass();
		t_user();
		t_sample_extest();
		t_cfg_rb();
		t_opt_off();
		tally_and_finish();
	end

	// about 230 test clock periods expected; allow over five times that
	initial begin
		#200us;
		miscompares++;
		tally_and_finish();
	end
endmodule : tb

bind fbs_tap fbs_tap_chk #(.N_IOB(N_IOB)) u_chk (.clk(clk), .reset(reset),
	.scan_option_en(scan_option_en), .tck_pin(tck_pin), .tdi_pin(tdi_pin),
	.tdo_pin_out(tdo_pin_out), .tdo_pin_oe(tdo_pin_oe),
	.user_instr_select_a(user_instr_select_a), .user_instr_select_b(user_instr_select_b),
	.user_data_reg_clock(user_data_reg_clock), .user_idle_strobe(user_idle_strobe),
	.user_scan_tdi(user_scan_tdi), .config_scan_data(config_scan_data),
	.config_scan_strobe(config_scan_strobe), .readback_shift(readback_shift));

`default_nettype wire
